// *** rtl/csrm_config_select.sv ***
// strap latch, configuration loading, serial target and input choice
// Functional notes
// - the strap level is caught once after power-on and held.
// - a high strap makes the two shared pins configuration selects.
// - a low strap makes the shared pins the serial data and clock.
// - after sampling the strap pin is driven as a reference output.
// - with a high strap the select pins pick slot 0 to 3, no serial access.
// - with a low strap pins are ignored; flag 1 loads defaults, 0 slot 0.
// - with a low strap only serial commands change configuration.
// - pin changes count only after 10 ms, high strap and flag 0.
// - a pin change loads the new slot, then 1 ms settle is kept.
// - in manual mode the input pin picks the reference, low is the primary.
// - in manual mode crystal is chosen when primary bit equals the pin, else diff.
// - the primary bit names the primary reference, 0 crystal, 1 diff.
// - the primary bit is bit 1 of reference_primary_reg, serially writable.
// - manual pin selection only while the mode field upper bit is 0.
// - reference changes are glitch free at the output.
`timescale 1ns/1ns
`include "csrm_defines.svh"

module csrm_config_select
#(
  parameter int SEL_HOLD_CYCLES = `CSRM_SEL_HOLD_MS * `CSRM_CLK_KHZ,
  parameter int SETTLE_CYCLES = `CSRM_SETTLE_MS * `CSRM_CLK_KHZ,
  parameter csrm_pkg::csrm_cfg_type [`CSRM_SLOTS-1:0] STORED_CONFIGS = '0
)
(
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // strap / reference output pin
  input wire logic pin_mode_strap_i,
  output logic pin_mode_strap_o,
  output logic pin_mode_strap_oe,
  // shared select / serial pins
  input wire logic config_select_bit1_i,
  output logic config_select_bit1_o,
  output logic config_select_bit1_oe,
  input wire logic config_select_bit0_i,
  // reference inputs
  input wire logic reference_choice_pin,
  input wire logic crystal_or_single_ended_input,
  input wire logic differential_reference_input,
  input wire logic differential_reference_input_n,
  // status
  output logic [2:0] active_config_q,
  output logic config_settling,
  output logic active_diff_q
);

  localparam int HW = $clog2(SEL_HOLD_CYCLES + 1);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  if (SEL_HOLD_CYCLES < 1 || SETTLE_CYCLES < 1)
    $error("timing counts must be at least one cycle");

  csrm_pkg::csrm_boot_type st_q;
  csrm_pkg::csrm_i2c_type ist_q;
  csrm_pkg::csrm_cfg_type cfg_q;
  logic strap_q, drive_q, hold_done_q, ack_q, sda_oe_q, sda_q, scl_q;
  logic [HW-1:0] hold_q;
  logic [SW-1:0] settle_q;
  logic [1:0] applied_sel_q, sel;
  logic [3:0] cnt_q;
  logic [7:0] shreg_q, tx_q, ptr_q, rdata;
  logic i2c_en, start, stop, rise, fall, byte_end, i2c_wr, reload, sel_diff;

  assign sel = {config_select_bit1_i, config_select_bit0_i};

  // -----------------------------------------------------------------
  // strap capture and boot sequence
  // -----------------------------------------------------------------
  // the strap is caught by a clock edge after release, never by reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= csrm_pkg::CSRM_ST_SAMPLE;
    else
      unique case (st_q)
        csrm_pkg::CSRM_ST_SAMPLE: st_q <= csrm_pkg::CSRM_ST_BOOT;
        csrm_pkg::CSRM_ST_BOOT: st_q <= csrm_pkg::CSRM_ST_RUN;
        csrm_pkg::CSRM_ST_RUN: st_q <= csrm_pkg::CSRM_ST_RUN;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      strap_q <= 1'b0;
    else if (st_q == csrm_pkg::CSRM_ST_SAMPLE)
      strap_q <= pin_mode_strap_i;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      drive_q <= 1'b0;
    else if (st_q == csrm_pkg::CSRM_ST_SAMPLE)
      drive_q <= 1'b1;
  end

  assign pin_mode_strap_oe = drive_q;

  // -----------------------------------------------------------------
  // select pin timing: 10 ms quiet start, 1 ms settle per change
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= '0;
    else if (!hold_done_q)
      hold_q <= hold_q + HW'(1);
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_done_q <= 1'b0;
    else if (hold_q == HW'(SEL_HOLD_CYCLES - 1))
      hold_done_q <= 1'b1;
  end

  // a change seen while settling is served once the settle ends
  assign reload = st_q == csrm_pkg::CSRM_ST_RUN && strap_q && hold_done_q
    && !cfg_q.flag_reg[`CSRM_BIT_DEFAULT_FLAG] && settle_q == '0
    && sel != applied_sel_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      settle_q <= '0;
    else if (reload)
      settle_q <= SW'(SETTLE_CYCLES);
    else if (settle_q != '0)
      settle_q <= settle_q - SW'(1);
  end

  assign config_settling = settle_q != '0;

  // -----------------------------------------------------------------
  // configuration image: boot load, pin reload, serial writes
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= '0;
      active_config_q <= 3'h0;
      applied_sel_q <= 2'h0;
    end
    else if (st_q == csrm_pkg::CSRM_ST_BOOT && strap_q)
    begin
      cfg_q <= STORED_CONFIGS[{1'b0, sel}];
      active_config_q <= {1'b0, sel};
      applied_sel_q <= sel;
    end
    else if (st_q == csrm_pkg::CSRM_ST_BOOT)
    begin
      if (STORED_CONFIGS[0].flag_reg[`CSRM_BIT_DEFAULT_FLAG])
      begin
        cfg_q <= STORED_CONFIGS[`CSRM_SLOT_I2C_DEFAULTS];
        active_config_q <= `CSRM_SLOT_I2C_DEFAULTS;
      end
      else
      begin
        cfg_q <= STORED_CONFIGS[0];
        active_config_q <= 3'h0;
      end
    end
    else if (reload)
    begin
      cfg_q <= STORED_CONFIGS[{1'b0, sel}];
      active_config_q <= {1'b0, sel};
      applied_sel_q <= sel;
    end
    else if (i2c_wr && ptr_q == `CSRM_OFS_DEFAULT_FLAG)
      cfg_q.flag_reg <= shreg_q;
    else if (i2c_wr && ptr_q == `CSRM_OFS_REF_PRIMARY)
      cfg_q.ref_ctrl <= shreg_q;
  end

  always_comb
  begin
    rdata = 8'h00;
    if (ptr_q == `CSRM_OFS_DEFAULT_FLAG)
      rdata = cfg_q.flag_reg;
    else if (ptr_q == `CSRM_OFS_REF_PRIMARY)
      rdata = cfg_q.ref_ctrl;
  end

  // -----------------------------------------------------------------
  // serial target on the shared pins
  // -----------------------------------------------------------------
  assign i2c_en = st_q == csrm_pkg::CSRM_ST_RUN && !strap_q;
  assign start = scl_q && config_select_bit0_i && sda_q
    && !config_select_bit1_i;
  assign stop = scl_q && config_select_bit0_i && !sda_q
    && config_select_bit1_i;
  assign rise = config_select_bit0_i && !scl_q;
  assign fall = !config_select_bit0_i && scl_q;
  assign byte_end = fall && !ack_q && cnt_q == `CSRM_BITS_PER_BYTE;
  assign i2c_wr = i2c_en && byte_end && ist_q == csrm_pkg::CSRM_I_WDAT;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_q <= 1'b1;
      scl_q <= 1'b1;
    end
    else
    begin
      sda_q <= config_select_bit1_i;
      scl_q <= config_select_bit0_i;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ist_q <= csrm_pkg::CSRM_I_IDLE;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cnt_q <= 4'h0;
      shreg_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
    end
    else if (!i2c_en || stop)
    begin
      ist_q <= csrm_pkg::CSRM_I_IDLE;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else if (start)
    begin
      ist_q <= csrm_pkg::CSRM_I_ADDR;
      ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (rise && ist_q != csrm_pkg::CSRM_I_IDLE)
    begin
      if (!ack_q)
      begin
        shreg_q <= {shreg_q[6:0], config_select_bit1_i};
        cnt_q <= cnt_q + `CSRM_BIT_ONE;
      end
      else if (ist_q == csrm_pkg::CSRM_I_RDAT && config_select_bit1_i)
        ist_q <= csrm_pkg::CSRM_I_IDLE;
    end
    else if (fall && ist_q != csrm_pkg::CSRM_I_IDLE)
    begin
      if (ack_q)
      begin
        ack_q <= 1'b0;
        cnt_q <= 4'h0;
        sda_oe_q <= ist_q == csrm_pkg::CSRM_I_RDAT && !tx_q[7];
      end
      else if (byte_end)
      begin
        ack_q <= 1'b1;
        cnt_q <= 4'h0;
        sda_oe_q <= ist_q != csrm_pkg::CSRM_I_RDAT;
        unique case (ist_q)
          csrm_pkg::CSRM_I_ADDR:
            if (shreg_q[7:1] != `CSRM_TARGET_ADDR)
            begin
              ist_q <= csrm_pkg::CSRM_I_IDLE;
              sda_oe_q <= 1'b0;
            end
            else if (shreg_q[0])
            begin
              ist_q <= csrm_pkg::CSRM_I_RDAT;
              tx_q <= rdata;
              ptr_q <= ptr_q + `CSRM_PTR_STEP;
            end
            else
              ist_q <= csrm_pkg::CSRM_I_REG;
          csrm_pkg::CSRM_I_REG:
          begin
            ptr_q <= shreg_q;
            ist_q <= csrm_pkg::CSRM_I_WDAT;
          end
          csrm_pkg::CSRM_I_WDAT: ptr_q <= ptr_q + `CSRM_PTR_STEP;
          csrm_pkg::CSRM_I_RDAT:
          begin
            tx_q <= rdata;
            ptr_q <= ptr_q + `CSRM_PTR_STEP;
          end
          default: ist_q <= csrm_pkg::CSRM_I_IDLE;
        endcase
      end
      else if (ist_q == csrm_pkg::CSRM_I_RDAT)
        sda_oe_q <= !tx_q[3'(`CSRM_BIT_MSB - cnt_q[2:0])];
    end
  end

  // open drain: only ever pulls low
  assign config_select_bit1_o = 1'b0;
  assign config_select_bit1_oe = sda_oe_q;

  // -----------------------------------------------------------------
  // reference choice
  // -----------------------------------------------------------------
  // outside manual mode the primary input is simply held
  assign sel_diff = !cfg_q.ref_ctrl.switchover_mode_field[1]
    ? cfg_q.ref_ctrl.primary_source_bit ^ reference_choice_pin
    : cfg_q.ref_ctrl.primary_source_bit;

  csrm_ref_switch u_switch
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sel_diff(sel_diff),
    .xin_level(crystal_or_single_ended_input),
    .diff_level(differential_reference_input
      & ~differential_reference_input_n),
    .ref_out_q(pin_mode_strap_o),
    .active_diff_q(active_diff_q)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  strap_held_a: assert property (
    st_q != csrm_pkg::CSRM_ST_SAMPLE |=> $stable(strap_q))
    else $error("strap value changed after sampling");
  strap_drive_a: assert property (
    st_q != csrm_pkg::CSRM_ST_SAMPLE |-> pin_mode_strap_oe)
    else $error("strap pin not driven after sampling");
  pin_mode_quiet_a: assert property (
    strap_q && st_q == csrm_pkg::CSRM_ST_RUN
    |=> ist_q == csrm_pkg::CSRM_I_IDLE && !config_select_bit1_oe)
    else $error("serial target active with high strap");
  boot_pin_load_a: assert property (
    st_q == csrm_pkg::CSRM_ST_BOOT && strap_q
    |=> active_config_q == {1'b0, $past(sel)})
    else $error("boot slot does not follow select pins");
  boot_serial_load_a: assert property (
    st_q == csrm_pkg::CSRM_ST_BOOT && !strap_q
    |=> active_config_q
      == (STORED_CONFIGS[0].flag_reg[`CSRM_BIT_DEFAULT_FLAG]
      ? `CSRM_SLOT_I2C_DEFAULTS : 3'h0))
    else $error("boot slot wrong with low strap");
  pins_ignored_a: assert property (
    st_q == csrm_pkg::CSRM_ST_RUN && !strap_q
    |=> $stable(active_config_q))
    else $error("slot changed with low strap");
  early_change_a: assert property (
    st_q == csrm_pkg::CSRM_ST_RUN && !hold_done_q
    |=> $stable(active_config_q))
    else $error("slot changed inside the quiet start");
  settle_load_a: assert property (
    reload |=> config_settling && active_config_q == {1'b0, $past(sel)}
    ##1 $stable(active_config_q))
    else $error("pin change not loaded or settle missing");
  serial_first_a: assert property (
    st_q != csrm_pkg::CSRM_ST_RUN
    |-> ist_q == csrm_pkg::CSRM_I_IDLE && !sda_oe_q)
    else $error("serial target awake before boot load");
  primary_write_a: assert property (
    i2c_wr && ptr_q == `CSRM_OFS_REF_PRIMARY
    |=> cfg_q.ref_ctrl.primary_source_bit == $past(shreg_q[1]))
    else $error("primary bit not written");
  manual_pick_a: assert property (
    !cfg_q.ref_ctrl.switchover_mode_field[1]
    && reference_choice_pin == cfg_q.ref_ctrl.primary_source_bit
    |-> !sel_diff)
    else $error("wrong reference in manual mode");

  pin_reload_c: cover property (reload ##1 config_settling);
  serial_write_c: cover property (i2c_wr);
  ref_swap_c: cover property ($changed(active_diff_q));

endmodule // csrm_config_select

// *** rtl/csrm_defines.svh ***
// constants for the configuration select and reference mux block
`ifndef CSRM_DEFINES_SVH
`define CSRM_DEFINES_SVH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define CSRM_OFS_DEFAULT_FLAG 8'h00
`define CSRM_OFS_REF_PRIMARY 8'h13
`define CSRM_BIT_DEFAULT_FLAG 7
`define CSRM_PTR_STEP 8'h01

// -----------------------------------------------------------------
// serial target
// -----------------------------------------------------------------
`define CSRM_TARGET_ADDR 7'h6a
`define CSRM_BITS_PER_BYTE 4'h8
`define CSRM_BIT_ONE 4'h1
`define CSRM_BIT_MSB 3'h7

// -----------------------------------------------------------------
// configuration slots and timing
// -----------------------------------------------------------------
`define CSRM_SLOT_I2C_DEFAULTS 3'h4
`define CSRM_SLOTS 5
`define CSRM_CLK_KHZ 100000
`define CSRM_SEL_HOLD_MS 10
`define CSRM_SETTLE_MS 1
`define CSRM_SWITCH_GUARD 3'h4

`endif

// *** rtl/csrm_pkg.sv ***
// shared types for the configuration select and reference mux block
package csrm_pkg;

  // reference control register layout
  typedef struct packed {
    logic [1:0] switchover_mode_field;
    logic [3:0] spare;
    logic primary_source_bit;
    logic spare0;
  } csrm_ref_ctrl_type;

  // one stored configuration image
  typedef struct packed {
    logic [7:0] flag_reg;
    csrm_ref_ctrl_type ref_ctrl;
  } csrm_cfg_type;

  typedef enum logic [1:0] {
    CSRM_ST_SAMPLE,
    CSRM_ST_BOOT,
    CSRM_ST_RUN
  } csrm_boot_type;

  typedef enum logic [2:0] {
    CSRM_I_IDLE,
    CSRM_I_ADDR,
    CSRM_I_REG,
    CSRM_I_WDAT,
    CSRM_I_RDAT
  } csrm_i2c_type;

endpackage

// *** rtl/csrm_ref_switch.sv ***
// break-before-make reference selector with registered output
`timescale 1ns/1ns
`include "csrm_defines.svh"

module csrm_ref_switch
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // selection and sources
  input wire logic sel_diff,
  input wire logic xin_level,
  input wire logic diff_level,
  // result
  output logic ref_out_q,
  output logic active_diff_q
);

  logic [2:0] gap_q;
  logic src;

  assign src = active_diff_q ? diff_level : xin_level;

  // -----------------------------------------------------------------
  // handover: wait for the old source low, park low, then swap
  // -----------------------------------------------------------------
  // parking low avoids runt pulses when the two sources are unrelated
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_q <= 3'h0;
    else if (gap_q != 3'h0)
      gap_q <= gap_q - 3'h1;
    else if (sel_diff != active_diff_q && !ref_out_q)
      gap_q <= `CSRM_SWITCH_GUARD;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      active_diff_q <= 1'b0;
    else if (gap_q == 3'h1)
      active_diff_q <= sel_diff;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ref_out_q <= 1'b0;
    else if (gap_q != 3'h0)
      ref_out_q <= 1'b0;
    else if (sel_diff == active_diff_q)
      ref_out_q <= src;
    else
      ref_out_q <= ref_out_q & src;
  end

  ref_glitch_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(active_diff_q) |-> !ref_out_q && !$past(ref_out_q))
    else $error("source swapped while output high");

endmodule // csrm_ref_switch

// *** sim/csrm_host_model.sv ***
// serial host model driving the shared data and clock pins of the block
`timescale 1ns/1ns
`include "csrm_defines.svh"

module csrm_host_model
(
  // clock
  input wire logic ref_clk,
  // serial lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_low,
  // read result
  output logic [7:0] rd_byte,
  output logic rd_done
);
  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  // four cycles a phase keeps scl well above the two-cycle floor
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_byte = 8'h00;
    rd_done = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask

  // data moves only while scl is low, sampled while scl is high
  task automatic bit_io(input logic b, output logic got);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    got = sda_line;
    scl = 1'b0;
    half();
  endtask

  task automatic start_c();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask

  task automatic stop_c();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // ninth bit is released: target ack on writes, host nack on reads
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
    output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], g);
      rx[i] = g;
    end
    bit_io(1'b1, ack);
  endtask

  // ---------------------------------------------------------------
  // transactions
  // ---------------------------------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
    output logic [2:0] acks);
    logic [7:0] rx;
    start_c();
    byte_io({`CSRM_TARGET_ADDR, 1'b0}, rx, acks[2]);
    byte_io(a, rx, acks[1]);
    byte_io(d, rx, acks[0]);
    stop_c();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [2:0] acks);
    logic [7:0] rx;
    logic n;
    start_c();
    byte_io({`CSRM_TARGET_ADDR, 1'b0}, rx, acks[2]);
    byte_io(a, rx, acks[1]);
    stop_c();
    start_c();
    byte_io({`CSRM_TARGET_ADDR, 1'b1}, rx, acks[0]);
    byte_io(8'hff, rx, n);
    stop_c();
    rd_byte = rx;
    rd_done = 1'b1;
    @(negedge ref_clk);
    rd_done = 1'b0;
  endtask

  task automatic send_raw(input logic [7:0] b, output logic ack);
    logic [7:0] rx;
    start_c();
    byte_io(b, rx, ack);
    stop_c();
  endtask
endmodule // csrm_host_model

// *** sim/tb.sv ***
// testbench for the configuration select and reference mux block
`timescale 1ns/1ns
`include "csrm_defines.svh"

module tb;
  // ---------------------------------------------------------------
  // settings and signals
  // ---------------------------------------------------------------
  localparam int HOLD = 20;
  localparam int SETTLE = 10;
  // slot 0 sets the default flag, slot 4 carries a marker in its flag
  localparam csrm_pkg::csrm_cfg_type [`CSRM_SLOTS-1:0] CFGS =
    80'h3c00_0000_0000_0000_da00;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap_pull = 1'b0;
  logic config_select_bit1 = 1'b0;
  logic config_select_bit0 = 1'b0;
  logic choice = 1'b0;
  logic xin = 1'b0;
  logic diff_p = 1'b0;
  logic [7:0] seed = 8'h02;
  logic strap_o, strap_oe, b1_o, b1_oe, settling, diff_q;
  logic scl, sda_low, sda_line, rd_done;
  logic [2:0] cfg_q, acks, last_cfg;
  logic [2:0] prev_cfg = 3'h0;
  logic prev_diff = 1'b0;
  logic x_prev = 1'b0;
  logic p_prev = 1'b0;
  logic [7:0] wdat;
  logic last_diff;
  logic [7:0] rd_byte;
  logic [1:0] g;
  int fails = 0;
  int n_checks = 0;
  int cnt;
  logic [2:0] cfg_notes[$];
  logic diff_notes[$];
  logic [7:0] rd_notes[$];

  always #5 ref_clk = ~ref_clk;
  // open-drain data line with pull-up
  assign sda_line = ~(sda_low | (b1_oe & ~b1_o));

  csrm_config_select #(.SEL_HOLD_CYCLES(HOLD), .SETTLE_CYCLES(SETTLE),
    .STORED_CONFIGS(CFGS)) dut_u
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_mode_strap_i(strap_oe ? strap_o : strap_pull),
    .pin_mode_strap_o(strap_o),
    .pin_mode_strap_oe(strap_oe),
    .config_select_bit1_i(strap_pull ? config_select_bit1 : sda_line),
    .config_select_bit1_o(b1_o),
    .config_select_bit1_oe(b1_oe),
    .config_select_bit0_i(strap_pull ? config_select_bit0 : scl),
    .reference_choice_pin(choice),
    .crystal_or_single_ended_input(xin),
    .differential_reference_input(diff_p),
    .differential_reference_input_n(~diff_p),
    .active_config_q(cfg_q),
    .config_settling(settling),
    .active_diff_q(diff_q)
  );

  csrm_host_model host_u
  (
    .ref_clk(ref_clk),
    .sda_line(sda_line),
    .scl(scl),
    .sda_low(sda_low),
    .rd_byte(rd_byte),
    .rd_done(rd_done)
  );

  // ---------------------------------------------------------------
  // random reference levels
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  always @(negedge ref_clk)
  begin
    seed <= lfsr(seed);
    xin <= seed[0];
    diff_p <= seed[3];
  end

  // ---------------------------------------------------------------
  // compare and notes
  // ---------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask

  // a note is kept only for a real change, the monitors see only changes
  task automatic note_cfg(input logic [2:0] v);
    if (v !== last_cfg)
      cfg_notes.push_back(v);
    last_cfg = v;
  endtask

  task automatic note_diff(input logic v);
    if (v !== last_diff)
      diff_notes.push_back(v);
    last_diff = v;
  endtask

  // an unnoted change compares against the old value and so fails
  always @(posedge ref_clk)
  begin
    if (rst_n && cfg_q !== prev_cfg)
      cmp_byte({5'h00, cfg_q}, {5'h00, cfg_notes.size() ?
        cfg_notes.pop_front() : prev_cfg});
    prev_cfg = cfg_q;
    // output follows the active source one edge late once no swap is due
    if (rst_n && strap_oe === 1'b1 && diff_notes.size() == 0
      && diff_q === prev_diff)
      cmp_bit(strap_o, prev_diff ? p_prev : x_prev);
    if (rst_n && diff_q !== prev_diff)
      cmp_bit(diff_q, diff_notes.size() ?
        diff_notes.pop_front() : prev_diff);
    prev_diff = diff_q;
    x_prev = xin;
    p_prev = diff_p;
    if (rd_done === 1'b1)
      cmp_byte(rd_byte, rd_notes.size() ?
        rd_notes.pop_front() : ~rd_byte);
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic drain();
    cnt = 0;
    while (cfg_notes.size() + diff_notes.size() + rd_notes.size() != 0
      && cnt < 400)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    cmp_byte(8'(cfg_notes.size() + diff_notes.size()), 8'h00);
  endtask

  task automatic power_up(input logic strap, input logic [1:0] sel);
    rst_n = 1'b0;
    strap_pull = strap;
    {config_select_bit1, config_select_bit0} = sel;
    last_cfg = 3'h0;
    last_diff = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    note_cfg(strap ? {1'b0, sel}
      : (CFGS[0].flag_reg[`CSRM_BIT_DEFAULT_FLAG]
      ? `CSRM_SLOT_I2C_DEFAULTS : 3'h0));
    repeat (3) @(negedge ref_clk);
    cmp_bit(strap_oe, 1'b1);
    cmp_bit(b1_o, 1'b0);
  endtask

  // a second pin change given inside the window must wait for its end
  task automatic settle_count(input logic change);
    cnt = 0;
    while (settling !== 1'b1 && cnt < 40)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    cnt = 0;
    if (change)
      config_select_bit0 = ~config_select_bit0;
    while (settling === 1'b1 && cnt < 40)
    begin
      @(negedge ref_clk);
      cnt++;
    end
    cmp_byte(8'(cnt), 8'(SETTLE));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.write_reg(a, d, acks);
    cmp_byte({5'h00, acks}, 8'h00);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_notes.push_back(exp);
    host_u.read_reg(a, acks);
    cmp_byte({5'h00, acks}, 8'h00);
  endtask

  task automatic end_test(input string name);
    drain();
    $display("test %s done", name);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    for (int v = 0; v < 4; v++)
    begin
      power_up(1'b1, v[1:0]);
      drain();
    end
    end_test("boot_slots");
    power_up(1'b1, 2'h1);
    config_select_bit1 = 1'b1;
    repeat (HOLD - 8) @(negedge ref_clk);
    note_cfg(3'h3);
    settle_count(1'b1);
    note_cfg(3'h2);
    settle_count(1'b0);
    end_test("pin_reload");
    power_up(1'b0, 2'h3);
    rd(8'h00, 8'h3c);
    wdat = seed;
    wr(8'h00, wdat);
    rd(8'h00, wdat);
    rd(8'h05, 8'h00);
    host_u.send_raw(8'ha0, acks[0]);
    cmp_bit(acks[0], 1'b1);
    end_test("serial_regs");
    for (int k = 0; k < 4; k++)
    begin
      g = 2'(k ^ (k >> 1));
      // the swap may land inside the write, so the note goes first
      note_diff(g[1] ^ g[0]);
      wr(8'h13, {6'h00, g[1], 1'b0});
      choice = g[0];
      drain();
    end
    note_diff(1'b0);
    wr(8'h13, 8'h80);
    drain();
    choice = 1'b1;
    repeat (100) @(negedge ref_clk);
    choice = 1'b0;
    note_diff(1'b1);
    wr(8'h13, 8'h42);
    rd(8'h13, 8'h42);
    end_test("ref_select");
    report_and_stop();
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
endmodule // tb
